// ==== inc/hlt_pkg.sv ====
/*
  hlt_pkg: constants shared by the hardware limit period timer, its
  external reset source model and its self-checking bench.
  assumes: nothing; every user writes hlt_pkg::name, nothing is imported.
*/
package hlt_pkg;
  // data widths
  localparam int CNT_W = 8;
  localparam int MODE_W = 5;
  localparam int PRESCALE_SELECT_W = 3;
  localparam int POSTSCALE_SELECT_W = 4;
  localparam int PRE_W = 7;
  localparam int SEL_W = 5;
  localparam int SRC_N = 32;
  // values after reset
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'hFF;
  localparam logic [4:0] MODE_RST = 5'h00;
  // timer control word layout: on bit, prescale field, postscale field
  localparam int CTRL_ON_POS = 7;
  localparam int CTRL_PRESCALE_SELECT_POS = 4;
  localparam int CTRL_POSTSCALE_SELECT_POS = 0;
  // mode groups held in mode bits 4:3
  localparam logic [1:0] GRP_FREE = 2'h0;
  localparam logic [1:0] GRP_ONESHOT = 2'h1;
  localparam logic [1:0] GRP_MONO = 2'h2;
  localparam logic [1:0] GRP_RSVD = 2'h3;
  // mode codes
  localparam logic [4:0] M_SW_GATE = 5'h00;
  localparam logic [4:0] M_GATE_HI = 5'h01;
  localparam logic [4:0] M_GATE_LO = 5'h02;
  localparam logic [4:0] M_RST_ANY = 5'h03;
  localparam logic [4:0] M_RST_RISE = 5'h04;
  localparam logic [4:0] M_RST_FALL = 5'h05;
  localparam logic [4:0] M_RST_LO = 5'h06;
  localparam logic [4:0] M_RST_HI = 5'h07;
  localparam logic [4:0] M_OS_SW = 5'h08;
  localparam logic [4:0] M_OS_RISE = 5'h09;
  localparam logic [4:0] M_OS_FALL = 5'h0A;
  localparam logic [4:0] M_OS_ANY = 5'h0B;
  localparam logic [4:0] M_OS_RRST = 5'h0C;
  localparam logic [4:0] M_OS_FRST = 5'h0D;
  localparam logic [4:0] M_OS_RLO = 5'h0E;
  localparam logic [4:0] M_OS_FHI = 5'h0F;
  localparam logic [4:0] M_MS_RISE = 5'h11;
  localparam logic [4:0] M_MS_FALL = 5'h12;
  localparam logic [4:0] M_MS_ANY = 5'h13;
  localparam logic [4:0] M_LOS_LO = 5'h16;
  localparam logic [4:0] M_LOS_HI = 5'h17;
  // far-side timing, in timer clock periods
  localparam int EDGE_GAP_MIN = 6;
  localparam int LEVEL_MIN = 3;
endpackage

// ==== inc/hlt_sync_if.sv ====
/*
  hlt_sync_if: carries the selected external reset signal into the
  synchroniser and its clean copy back out.
  assumes: both ends run on the same clk.
*/
`timescale 1ns/1ns
interface hlt_sync_if;
  logic raw;  // selected source, not yet synchronised
  logic sync; // level after two flops
  modport sync_side (input raw, output sync);
  modport user_side (output raw, input sync);
endinterface

// ==== src/hlt_sync.sv ====
/*
  hlt_sync: two-flop synchroniser for the external reset signal.
  assumes: clk, rst and ce are those of the timer; raw may be asynchronous.
*/
`timescale 1ns/1ns
module hlt_sync (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // signal path
  hlt_sync_if.sync_side sif
);
  typedef struct packed {
    logic meta; // first stage, read only by the second
    logic q;    // second stage
  } hlt_sync_t;

  hlt_sync_t s_r; // registered state
  hlt_sync_t s_nxt; // next state

  // shift the raw level through both stages
  always_comb begin
    s_nxt = s_r;
    s_nxt.meta = sif.raw;
    s_nxt.q = s_r.meta;
  end

  // register; ce low freezes the chain
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign sif.sync = s_r.q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // output trails the input by exactly two enabled cycles
  a_sync_depth: assert property (ce ##1 ce |=> sif.sync == $past(sif.raw, 2))
    else $error("synchroniser depth wrong");
endmodule

// ==== src/hlt_timer.sv ====
/*
  hlt_timer: 8-bit period timer with selectable external reset source,
  hardware limit modes, prescaler, postscaler and period pulse.
  assumes: software writes arrive as one-cycle strobes with data; the
  timer clock is a one-cycle enable tmr_clk_en on clk; the external
  source keeps its own spacing and level-length limits.
*/
// Contract
// - source select picks external reset input
// - mode bits 4:3 pick mode group
// - debug freeze ignores all external triggers
// - software gate counts while on set
// - period match wraps counter to zero
// - hardware gate: 00001 high, 00010 low
// - edge modes clear counter on edge
// - level modes hold counter in reset
// - software one-shot clears on, stops zero
// - edge one-shot starts on chosen edge
// - fresh edge needed after on cycles
// - edge start, same edges then reset
// - edge start, level reset one-shot
// - monostable stops at zero, keeps on
// - level one-shot, match or off stops
// - postscaled pulse, irq gated by enable
// - on and input need two-cycle sync
// - match advances postscaler, one-cycle pulse
// - double-buffered period, reset FFh, reloads
// - control, count writes and resets clear prescaler, postscaler
`timescale 1ns/1ns
module hlt_timer (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // timer clock source, one pulse per timer clock
  input wire logic tmr_clk_en,
  // external reset source selection
  input wire logic [31:0] ers_sources,
  input wire logic [4:0] reset_source_select,
  input wire logic debug_freeze,
  // software writes
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic hlt_wr,
  input wire logic [4:0] hlt_wdata,
  input wire logic count_wr,
  input wire logic [7:0] count_wdata,
  input wire logic period_wr,
  input wire logic [7:0] period_wdata,
  input wire logic timer_irq_enable,
  // status
  output logic [7:0] timer_count,
  output logic [7:0] period_value,
  output logic [7:0] period_register,
  output logic on_status,
  output logic [4:0] hardware_limit_control,
  // events
  output logic postscaled_pulse,
  output logic irq_request
);
  typedef struct packed {
    logic [7:0] cnt;    // timer count
    logic [7:0] pbuf;   // software-visible period
    logic [7:0] pact;   // active period compared against
    logic on;           // on bit
    logic on_d;         // on bit seen one timer clock ago
    logic [4:0] mode;   // hardware limit mode
    logic [2:0] prescale_select;   // prescale select
    logic [3:0] postscale_select;  // postscale select
    logic [6:0] pre;    // prescaler count
    logic [3:0] post;   // postscaler count
    logic armed;        // edge start seen, counting allowed
    logic lvl;          // external level as last accepted
    logic rpend;        // rising edge waiting for a timer clock
    logic fpend;        // falling edge waiting for a timer clock
    logic pulse;        // postscaled output pulse
    logic irq;          // gated interrupt request
  } hlt_state_t;

  hlt_state_t s_r; // registered state
  hlt_state_t s_nxt; // next state
  logic tick; // prescaled timer clock
  logic run; // counter may advance
  logic hrst; // hardware reset of the counter
  logic arm; // start edge accepted
  logic os; // one-shot: match clears on
  logic ms; // monostable: match disarms only
  logic lvl_now; // external level used this cycle
  logic re_t; // rising edge for this tick
  logic fe_t; // falling edge for this tick
  logic on_ok; // on bit past its sync delay
  logic match; // counter equals active period

  hlt_sync_if sif ();

  // external source mux
  assign sif.raw = ers_sources[reset_source_select];

  hlt_sync u_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .sif(sif)
  );

  // prescaler full: count reaches 2^prescale_select - 1
  function automatic logic pre_full(input logic [6:0] p, input logic [2:0] k);
    logic [6:0] lim;
    lim = 7'(({7'h00, 1'b1} << k) - 8'h01);
    return p == lim;
  endfunction

  // reserved codes: whole group 11, 10000, 10100, 10101
  function automatic logic mode_rsvd(input logic [4:0] m);
    return (m[4:3] == hlt_pkg::GRP_RSVD) || (m == 5'h10) ||
           (m == 5'h14) || (m == 5'h15);
  endfunction

  // next state
  always_comb begin
    s_nxt = s_r;
    run = 1'b0;
    hrst = 1'b0;
    arm = 1'b0;
    os = 1'b0;
    ms = 1'b0;
    // freeze holds the accepted level, so no edge can appear
    lvl_now = debug_freeze ? s_r.lvl : sif.sync;
    s_nxt.lvl = lvl_now;
    // edges come only from the synchronised copy
    re_t = s_r.rpend | (lvl_now & ~s_r.lvl);
    fe_t = s_r.fpend | (~lvl_now & s_r.lvl);
    tick = tmr_clk_en & pre_full(s_r.pre, s_r.prescale_select);
    // edges between timer clocks wait here; consumed at the tick
    s_nxt.rpend = tick ? 1'b0 : re_t;
    s_nxt.fpend = tick ? 1'b0 : fe_t;
    // on must survive a timer clock before it counts
    on_ok = s_r.on & s_r.on_d;
    match = s_r.cnt == s_r.pact;
    s_nxt.pulse = 1'b0;
    s_nxt.irq = 1'b0;
    if (tmr_clk_en) begin
      s_nxt.pre = tick ? 7'h00 : 7'(s_r.pre + 7'h01);
    end
    // an off bit drops the history at once, so a quick off-on still waits
    s_nxt.on_d = tick ? s_r.on : (s_r.on_d & s_r.on);
    // mode decode; group comes from mode bits 4:3
    case (s_r.mode)
      hlt_pkg::M_SW_GATE: begin
        run = on_ok;
      end
      hlt_pkg::M_GATE_HI: begin
        run = on_ok & lvl_now;
      end
      hlt_pkg::M_GATE_LO: begin
        run = on_ok & ~lvl_now;
      end
      hlt_pkg::M_RST_ANY: begin
        run = on_ok;
        hrst = on_ok & (re_t | fe_t);
      end
      hlt_pkg::M_RST_RISE: begin
        run = on_ok;
        hrst = on_ok & re_t;
      end
      hlt_pkg::M_RST_FALL: begin
        run = on_ok;
        hrst = on_ok & fe_t;
      end
      hlt_pkg::M_RST_LO: begin
        run = on_ok & lvl_now;
        hrst = on_ok & ~lvl_now;
      end
      hlt_pkg::M_RST_HI: begin
        run = on_ok & ~lvl_now;
        hrst = on_ok & lvl_now;
      end
      hlt_pkg::M_OS_SW: begin
        run = on_ok;
        os = 1'b1;
      end
      hlt_pkg::M_OS_RISE: begin
        arm = on_ok & re_t;
        run = on_ok & s_r.armed;
        os = 1'b1;
      end
      hlt_pkg::M_OS_FALL: begin
        arm = on_ok & fe_t;
        run = on_ok & s_r.armed;
        os = 1'b1;
      end
      hlt_pkg::M_OS_ANY: begin
        arm = on_ok & (re_t | fe_t);
        run = on_ok & s_r.armed;
        os = 1'b1;
      end
      hlt_pkg::M_OS_RRST: begin
        // first edge starts, every later one restarts from zero
        arm = on_ok & ~s_r.armed & re_t;
        hrst = on_ok & s_r.armed & re_t;
        run = on_ok & s_r.armed;
        os = 1'b1;
      end
      hlt_pkg::M_OS_FRST: begin
        arm = on_ok & ~s_r.armed & fe_t;
        hrst = on_ok & s_r.armed & fe_t;
        run = on_ok & s_r.armed;
        os = 1'b1;
      end
      hlt_pkg::M_OS_RLO: begin
        arm = on_ok & re_t;
        hrst = on_ok & ~lvl_now;
        run = on_ok & s_r.armed & lvl_now;
        os = 1'b1;
      end
      hlt_pkg::M_OS_FHI: begin
        arm = on_ok & fe_t;
        hrst = on_ok & lvl_now;
        run = on_ok & s_r.armed & ~lvl_now;
        os = 1'b1;
      end
      hlt_pkg::M_MS_RISE: begin
        arm = on_ok & ~s_r.armed & re_t;
        run = on_ok & s_r.armed;
        ms = 1'b1;
      end
      hlt_pkg::M_MS_FALL: begin
        arm = on_ok & ~s_r.armed & fe_t;
        run = on_ok & s_r.armed;
        ms = 1'b1;
      end
      hlt_pkg::M_MS_ANY: begin
        arm = on_ok & ~s_r.armed & (re_t | fe_t);
        run = on_ok & s_r.armed;
        ms = 1'b1;
      end
      hlt_pkg::M_LOS_LO: begin
        run = on_ok & lvl_now;
        hrst = ~lvl_now;
        os = 1'b1;
      end
      hlt_pkg::M_LOS_HI: begin
        run = on_ok & ~lvl_now;
        hrst = lvl_now;
        os = 1'b1;
      end
      default: begin
        // reserved codes: counter stands, input ignored
        run = 1'b0;
      end
    endcase
    // counter step, once per prescaled timer clock
    if (tick) begin
      if (arm) begin
        s_nxt.armed = 1'b1;
      end
      if (hrst) begin
        // external reset event: counter, scalers cleared, period reloaded
        s_nxt.cnt = hlt_pkg::COUNT_RST;
        s_nxt.pre = 7'h00;
        s_nxt.post = 4'h0;
        s_nxt.pact = s_r.pbuf;
      end else if (run) begin
        if (match) begin
          s_nxt.cnt = hlt_pkg::COUNT_RST;
          s_nxt.pact = s_r.pbuf;
          // postscaler advances on each match
          if (s_r.post == s_r.postscale_select) begin
            s_nxt.post = 4'h0;
            s_nxt.pulse = 1'b1;
            s_nxt.irq = timer_irq_enable;
          end else begin
            s_nxt.post = 4'(s_r.post + 4'h1);
          end
          if (os) begin
            s_nxt.on = 1'b0;
            s_nxt.armed = 1'b0;
          end
          if (ms) begin
            s_nxt.armed = 1'b0;
          end
        end else begin
          s_nxt.cnt = 8'(s_r.cnt + 8'h01);
        end
      end
    end
    // an off timer forgets its start edge
    if (!s_r.on) begin
      s_nxt.armed = 1'b0;
    end
    // software writes take priority over the counter step
    if (period_wr) begin
      s_nxt.pbuf = period_wdata;
    end
    if (hlt_wr) begin
      s_nxt.mode = hlt_wdata;
      // a new mode needs its own start edge, never one left from the old mode
      s_nxt.armed = 1'b0;
      s_nxt.pact = s_r.pbuf;
    end
    if (ctrl_wr) begin
      // counter itself is kept on a control write
      s_nxt.on = ctrl_wdata[hlt_pkg::CTRL_ON_POS];
      s_nxt.prescale_select = ctrl_wdata[hlt_pkg::CTRL_PRESCALE_SELECT_POS +: hlt_pkg::PRESCALE_SELECT_W];
      s_nxt.postscale_select = ctrl_wdata[hlt_pkg::CTRL_POSTSCALE_SELECT_POS +: hlt_pkg::POSTSCALE_SELECT_W];
      s_nxt.pre = 7'h00;
      s_nxt.post = 4'h0;
      s_nxt.pact = s_r.pbuf;
    end
    if (count_wr) begin
      s_nxt.cnt = count_wdata;
      s_nxt.pre = 7'h00;
      s_nxt.post = 4'h0;
      s_nxt.pact = s_r.pbuf;
    end
  end

  // register; ce low freezes everything, writes included
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.pbuf <= hlt_pkg::PERIOD_RST;
      s_r.pact <= hlt_pkg::PERIOD_RST;
      s_r.mode <= hlt_pkg::MODE_RST;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from state
  assign timer_count = s_r.cnt;
  assign period_value = s_r.pact;
  assign period_register = s_r.pbuf;
  assign on_status = s_r.on;
  assign hardware_limit_control = s_r.mode;
  assign postscaled_pulse = s_r.pulse;
  assign irq_request = s_r.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_quiet;
    !count_wr && !ctrl_wr && !hlt_wr;
  endsequence

  sequence s_os_end;
    ce && tick && run && match && !hrst && s_r.mode == hlt_pkg::M_OS_SW;
  endsequence

  a_reserved_hold: assert property (ce && mode_rsvd(s_r.mode) && !count_wr |=>
    s_r.cnt == $past(s_r.cnt)) else $error("reserved mode moved counter");
  a_freeze_ignore: assert property (ce && debug_freeze |=>
    s_r.lvl == $past(s_r.lvl)) else $error("trigger accepted in freeze");
  a_wrap_zero: assert property (ce && tick && run && match && !hrst && !count_wr |=>
    s_r.cnt == 8'h00) else $error("no wrap on period match");
  a_sw_gate_hold: assert property (ce && s_r.mode == hlt_pkg::M_SW_GATE && !s_r.on &&
    !count_wr |=> $stable(s_r.cnt)) else $error("counted with on clear");
  a_oneshot_end: assert property (s_os_end and s_quiet |=>
    !s_r.on && s_r.cnt == 8'h00) else $error("one-shot did not stop");
  a_mono_keep: assert property ((ce && tick && run && match && !hrst && ms) and s_quiet |=>
    s_r.on && !s_r.armed && s_r.cnt == 8'h00) else $error("monostable end wrong");
  a_rearm_edge: assert property (ce && !s_r.on |=> !s_r.armed)
    else $error("start edge kept while off");
  a_hw_reset: assert property (ce && tick && hrst && !count_wr |=>
    s_r.cnt == 8'h00 && s_r.post == 4'h0) else $error("hardware reset missed");
  a_gate_high: assert property (ce && tick && s_r.mode == hlt_pkg::M_GATE_HI && !lvl_now &&
    !count_wr |=> $stable(s_r.cnt)) else $error("gate low yet counting");
  a_irq_gate: assert property (s_r.irq |-> s_r.pulse)
    else $error("irq without postscaled pulse");
  a_period_load: assert property (ce && count_wr |=>
    s_r.pact == $past(s_r.pbuf)) else $error("period not reloaded");
  a_on_sync: assert property (ce && $rose(s_r.on) |-> !run)
    else $error("counted before on synchronised");
endmodule

// ==== verif/hlt_ers_model.sv ====
/*
  hlt_ers_model: far-side source of the external reset signal.
  assumes: the timer clock equals clk (tmr_clk_en held high), so spacing
  counted in clk cycles is spacing in timer clocks.
*/
`timescale 1ns/1ns
module hlt_ers_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request from the bench
  input wire logic [4:0] sel,
  input wire logic want,
  // lines to the timer
  output logic [31:0] ers,
  output logic level
);
  // two clocks of margin cover the timer's input synchroniser
  localparam int HOLD = hlt_pkg::EDGE_GAP_MIN + 2;
  int hold_r; // clocks since the last change of level
  logic [31:0] pat_r; // unselected lines keep toggling, never a stale value

  // level only moves after the minimum spacing has run out
  always_ff @(posedge clk) begin
    if (rst) begin
      level <= 1'b0;
      hold_r <= 0;
      pat_r <= 32'h5555_5555;
    end else begin
      pat_r <= ~pat_r;
      if (want !== level && hold_r >= HOLD) begin
        level <= want;
        hold_r <= 0;
      end else if (hold_r < HOLD) begin
        hold_r <= hold_r + 1;
      end
    end
  end

  // only the selected line carries the level
  assign ers = (pat_r & ~(32'h1 << sel)) | ({31'h0, level} << sel);
endmodule

// ==== verif/hlt_timer_tb.sv ====
/*
  hlt_timer_tb: self-checking bench for the hardware limit timer.
  assumes: hlt_pkg and hlt_ers_model are compiled first; timer clock = clk.
*/
`timescale 1ns/1ns
module hlt_timer_tb;
  // stimulus
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic tmr_clk_en = 1'b1; // held high except in the prescale scenario
  logic [4:0] sel = 5'h03;
  logic debug_freeze = 1'b0;
  logic ctrl_wr = 1'b0, hlt_wr = 1'b0, count_wr = 1'b0, period_wr = 1'b0;
  logic [7:0] ctrl_wdata = 8'h00, count_wdata = 8'h00, period_wdata = 8'h00;
  logic [4:0] hlt_wdata = 5'h00;
  logic timer_irq_enable = 1'b0, want = 1'b0;
  // observed
  wire logic [31:0] ers_sources;
  wire logic ers_level;
  logic [7:0] timer_count, period_value, period_register;
  logic [4:0] hardware_limit_control;
  logic on_status, postscaled_pulse, irq_request;
  int n_errors = 0, n_checks = 0;

  always #25 clk = ~clk;

  hlt_ers_model u_src (.clk(clk), .rst(rst), .sel(sel), .want(want), .ers(ers_sources),
    .level(ers_level));

  hlt_timer u_dut (.clk(clk), .rst(rst), .ce(ce), .tmr_clk_en(tmr_clk_en),
    .ers_sources(ers_sources), .reset_source_select(sel), .debug_freeze(debug_freeze),
    .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .hlt_wr(hlt_wr), .hlt_wdata(hlt_wdata),
    .count_wr(count_wr), .count_wdata(count_wdata), .period_wr(period_wr),
    .period_wdata(period_wdata), .timer_irq_enable(timer_irq_enable),
    .timer_count(timer_count), .period_value(period_value),
    .period_register(period_register), .on_status(on_status),
    .hardware_limit_control(hardware_limit_control), .postscaled_pulse(postscaled_pulse),
    .irq_request(irq_request));

  // inputs always move a fixed 5 ns after the rising edge
  task step;
    @(posedge clk);
    #5;
  endtask

  task cyc(input int n);
    repeat (n) step;
  endtask

  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle strobe: 0 control, 1 mode, 2 count, 3 period
  task wr(input logic [1:0] k, input logic [7:0] d);
    step;
    case (k)
      2'h0: begin ctrl_wr = 1'b1; ctrl_wdata = d; end
      2'h1: begin hlt_wr = 1'b1; hlt_wdata = d[4:0]; end
      2'h2: begin count_wr = 1'b1; count_wdata = d; end
      default: begin period_wr = 1'b1; period_wdata = d; end
    endcase
    step;
    {ctrl_wr, hlt_wr, count_wr, period_wr} = 4'h0;
  endtask

  // ask the source for a level and wait until it has really moved
  task set_ers(input logic l);
    int n;
    n = 0;
    want = l;
    while (ers_level !== l && n < 30) begin
      step;
      n++;
    end
  endtask

  // does the count move over six timer clocks
  task adv(input string what, input logic exp);
    logic [7:0] c0;
    c0 = timer_count;
    cyc(6);
    chk(what, {7'h0, exp}, {7'h0, timer_count !== c0});
  endtask

  task wait_cnt(input logic [7:0] v);
    int n;
    n = 0;
    while (timer_count !== v && n < 60) begin
      step;
      n++;
    end
    chk("count wait", v, timer_count);
  endtask

  task pulse_gap(output int n);
    n = 0;
    do begin
      step;
      n++;
    end while (postscaled_pulse !== 1'b1 && n < 40);
  endtask

  task t_reset;
    chk("count", hlt_pkg::COUNT_RST, timer_count);
    chk("period", hlt_pkg::PERIOD_RST, period_value);
    chk("period buf", hlt_pkg::PERIOD_RST, period_register);
    chk("on", 8'h00, {7'h0, on_status});
    chk("mode", {3'h0, hlt_pkg::MODE_RST}, {3'h0, hardware_limit_control});
  endtask

  // period wrap, pulse, interrupt gating and postscale spacing
  task t_free;
    int g;
    wr(3, 8'h03);
    chk("period buf", 8'h03, period_register);
    chk("period held", 8'hFF, period_value);
    timer_irq_enable = 1'b1;
    wr(0, 8'h80);
    chk("period load", 8'h03, period_value);
    wait_cnt(8'h03);
    step;
    chk("wrap", 8'h00, timer_count);
    chk("pulse", 8'h01, {7'h0, postscaled_pulse});
    chk("irq", 8'h01, {7'h0, irq_request});
    step;
    chk("after wrap", 8'h01, timer_count);
    timer_irq_enable = 1'b0;
    wr(0, 8'h81);
    pulse_gap(g);
    chk("irq masked", 8'h00, {7'h0, irq_request});
    pulse_gap(g);
    chk("postscale gap", 8'h08, g[7:0]);
  endtask

  // software gate, clock enable, then both hardware gates on another line
  task t_gate;
    wr(3, 8'hFF);
    wr(1, 8'h00);
    wr(0, 8'h80);
    cyc(3);
    adv("gate on", 1'b1);
    wr(0, 8'h00);
    cyc(3);
    adv("gate off", 1'b0);
    wr(0, 8'h80);
    cyc(3);
    ce = 1'b0;
    adv("ce low", 1'b0);
    ce = 1'b1;
    sel = 5'h1C;
    for (int m = 1; m <= 2; m++) begin
      for (int l = 0; l <= 1; l++) begin
        wr(1, m[7:0]);
        set_ers(l[0]);
        cyc(4);
        adv("hw gate", (m == 1) == (l == 1));
      end
    end
  endtask

  // edge reset modes against both edges, then an edge during freeze
  task t_edge;
    wr(0, 8'h80);
    for (int m = 3; m <= 5; m++) begin
      wr(1, m[7:0]);
      set_ers(1'b0);
      wr(2, 8'h00);
      cyc(20);
      set_ers(1'b1);
      cyc(10);
      chk("rise reset", {7'h0, m != 5}, {7'h0, timer_count < 8'h0F});
      cyc(20);
      set_ers(1'b0);
      cyc(10);
      chk("fall reset", {7'h0, m != 4}, {7'h0, timer_count < 8'h0F});
    end
    debug_freeze = 1'b1;
    cyc(20);
    set_ers(1'b1);
    set_ers(1'b0);
    cyc(10);
    chk("frozen edge", 8'h00, {7'h0, timer_count < 8'h0F});
    debug_freeze = 1'b0;
  endtask

  // level reset held, then release starts the count; bit 0 is the reset level
  task t_level;
    logic [4:0] tbl[6];
    tbl = '{5'h06, 5'h07, 5'h16, 5'h17, 5'h0E, 5'h0F};
    foreach (tbl[i]) begin
      wr(1, {3'h0, tbl[i]});
      wr(0, 8'h80);
      set_ers(tbl[i][0]);
      wr(2, 8'h05);
      cyc(5);
      chk("held", 8'h00, timer_count);
      set_ers(~tbl[i][0]);
      cyc(4);
      adv("released", 1'b1);
    end
  endtask

  task wait_on(input logic v);
    int n;
    n = 0;
    while (on_status !== v && n < 40) begin
      step;
      n++;
    end
    chk("on wait", {7'h0, v}, {7'h0, on_status});
  endtask

  task t_oneshot;
    wr(3, 8'h04);
    wr(1, 8'h08);
    chk("mode", 8'h08, {3'h0, hardware_limit_control});
    wr(2, 8'h00);
    wr(0, 8'h80);
    wait_on(1'b0);
    chk("stop", 8'h00, timer_count);
    cyc(3);
    chk("stays", 8'h00, timer_count);
  endtask

  // edge start, then a fresh edge after on is cycled
  task t_edge_os;
    wr(3, 8'hFF);
    set_ers(1'b0);
    wr(1, 8'h09);
    wr(2, 8'h00);
    wr(0, 8'h80);
    cyc(3);
    adv("no edge", 1'b0);
    set_ers(1'b1);
    cyc(4);
    adv("edge start", 1'b1);
    wr(0, 8'h00);
    cyc(3);
    adv("off", 1'b0);
    wr(0, 8'h80);
    cyc(3);
    adv("on, no edge", 1'b0);
    set_ers(1'b0);
    set_ers(1'b1);
    cyc(4);
    adv("fresh edge", 1'b1);
  endtask

  task t_mono;
    wr(3, 8'h04);
    set_ers(1'b0);
    wr(1, 8'h11);
    wr(2, 8'h00);
    wr(0, 8'h80);
    set_ers(1'b1);
    wait_cnt(8'h04);
    cyc(3);
    chk("mono stop", 8'h00, timer_count);
    chk("mono on", 8'h01, {7'h0, on_status});
    cyc(4);
    chk("mono stays", 8'h00, timer_count);
  endtask

  task t_rsvd;
    logic [4:0] tbl[5];
    tbl = '{5'h10, 5'h14, 5'h15, 5'h18, 5'h1F};
    foreach (tbl[i]) begin
      wr(1, {3'h0, tbl[i]});
      wr(2, 8'h00);
      wr(0, 8'h80);
      set_ers(~want);
      cyc(3);
      adv("reserved", 1'b0);
    end
  endtask

  // prescale 1:4 from a cleared prescaler, then the timer clock held off
  task t_presc;
    wr(1, 8'h00);
    wr(0, 8'hA0);
    wr(2, 8'h00);
    cyc(16);
    chk("prescaled", 8'h04, timer_count);
    tmr_clk_en = 1'b0;
    adv("no timer clock", 1'b0);
    tmr_clk_en = 1'b1;
  endtask

  task test_done;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // watchdog far beyond the thousand or so cycles the tests need
  initial begin
    #(50 * 20000);
    n_errors++;
    test_done;
  end

  initial begin
    repeat (3) @(posedge clk);
    #5;
    rst = 1'b0;
    t_reset;
    t_free;
    t_gate;
    t_edge;
    t_level;
    t_oneshot;
    t_edge_os;
    t_mono;
    t_rsvd;
    t_presc;
    test_done;
  end
endmodule
